// ---- csa_axis_cmd.sv ----
// Contract
// - A motion starts only on a rising edge of execute, never on a held level.
// - A falling execute does not disturb the motion in progress.
// - A new rising edge during motion restarts the command and re-latches all motion inputs.
// - Direction 1 is positive, 3 is negative, 4 keeps the present direction.
// - Transfer mode 0 interrupts the running command at once, 1 waits for it.
// - Axes 0 to 11 are valid in analog or pulse mode and 0 to 15 in fieldbus mode, default 0.
// - Busy and active rise a short delay after the edge, and at-target-speed rises on reaching speed.
// - An interrupt sets aborted and clears the other flags; aborted clears once execute is low. The code's abort leaves the error flag as it was.
// - Execute falling during acceleration still gives at-target-speed with busy and active kept.
// - At-target-speed stays high when an override later changes the target.
// - An override before the target is reached moves the goal to the overridden speed.
// - An error flag and a 16-bit error code report a failed command.
//
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module csa_axis_cmd #(
  parameter int RAMP_TICK_CYCLES = csa_pkg::RAMP_TICK_CYCLES,
  parameter int START_DELAY = csa_pkg::START_DELAY_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Motion status
  output logic signed [31:0] speed_out,
  output logic [3:0] axis_out,
  output logic busy_out,
  output logic active_out,
  output logic in_velocity_out,
  output logic aborted_flag_out,
  output logic error_out,
  output logic [15:0] error_code_out
);
  if (START_DELAY < 1 || START_DELAY > 65535 || RAMP_TICK_CYCLES < 1) begin : g_bad
    $error("csa_axis_cmd: unsupported timing parameters");
  end

  logic rst_q1;
  logic rst_n;
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // Bus handshake: waitrequest drops for one cycle per access
  wire req = avs_read_in | avs_write_in;
  wire acc_go = req & ~avs_waitrequest_out;
  wire wr_go = avs_write_in & acc_go;
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Software-held command inputs
  logic [31:0] ctrl;
  logic [31:0] vel_reg;
  logic [31:0] acc_reg;
  logic [31:0] dec_reg;
  logic [31:0] jerk_reg;
  logic [31:0] ovr_reg;
  logic ovr_valid;
  wire wr_ctrl = wr_go && avs_address_in == csa_pkg::OFS_CTRL;
  wire wr_ovr = wr_go && avs_address_in == csa_pkg::OFS_OVERRIDE;
  wire [31:0] next_ctrl = be_merge(ctrl, avs_writedata_in, avs_byteenable_in);
  // Abort bit is a write-one strobe and never stored
  wire abort_evt = wr_ctrl && next_ctrl[csa_pkg::CTRL_ABORT];
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= {csa_pkg::RST_WORD[31:4], csa_pkg::RST_DIR, 1'b0};
      vel_reg <= csa_pkg::RST_WORD;
      acc_reg <= csa_pkg::RST_WORD;
      dec_reg <= csa_pkg::RST_WORD;
      jerk_reg <= csa_pkg::RST_WORD;
    end else if (wr_go) begin
      unique case (avs_address_in)
        csa_pkg::OFS_CTRL: ctrl <= next_ctrl & ~(32'h0000_0001 << csa_pkg::CTRL_ABORT);
        csa_pkg::OFS_VEL: vel_reg <= be_merge(vel_reg, avs_writedata_in, avs_byteenable_in);
        csa_pkg::OFS_ACC: acc_reg <= be_merge(acc_reg, avs_writedata_in, avs_byteenable_in);
        csa_pkg::OFS_DEC: dec_reg <= be_merge(dec_reg, avs_writedata_in, avs_byteenable_in);
        csa_pkg::OFS_JERK: jerk_reg <= be_merge(jerk_reg, avs_writedata_in, avs_byteenable_in);
        default: begin
        end
      endcase
    end
  end

  wire exec_lvl = ctrl[csa_pkg::CTRL_EXEC];
  wire fieldbus = ctrl[csa_pkg::CTRL_FIELDBUS];
  wire axis_en = ctrl[csa_pkg::CTRL_AXIS_EN];
  logic exec_prev;
  wire exec_rise = exec_lvl & ~exec_prev;

  // Command presented at the pins; only captured on the rising edge
  csa_pkg::csa_cmd_t in_cmd;
  assign in_cmd.vel = vel_reg;
  assign in_cmd.acc = acc_reg;
  assign in_cmd.dec = dec_reg;
  assign in_cmd.jerk = jerk_reg;
  assign in_cmd.dir = ctrl[csa_pkg::CTRL_DIR_LSB +: 3];
  assign in_cmd.mode = ctrl[csa_pkg::CTRL_MODE];
  assign in_cmd.axis = ctrl[csa_pkg::CTRL_AXIS_LSB +: 4];

  // Validation of the presented command
  wire axis_bad = !fieldbus && (in_cmd.axis > csa_pkg::AXIS_MAX_LOCAL);
  wire dir_bad = !(in_cmd.dir == csa_pkg::DIR_POS || in_cmd.dir == csa_pkg::DIR_NEG ||
                   in_cmd.dir == csa_pkg::DIR_KEEP);
  wire param_bad = ($signed(in_cmd.vel) <= 0) || ($signed(in_cmd.acc) <= 0) ||
                   ($signed(in_cmd.dec) <= 0) || ($signed(in_cmd.jerk) <= 0);
  wire [15:0] chk_code = !axis_en ? csa_pkg::ERR_NOT_ENABLED :
                         axis_bad ? csa_pkg::ERR_AXIS :
                         dir_bad ? csa_pkg::ERR_DIR :
                         param_bad ? csa_pkg::ERR_PARAM : csa_pkg::ERR_NONE;
  wire cmd_ok = (chk_code == csa_pkg::ERR_NONE);

  // Motion state
  csa_pkg::csa_state_t state;
  csa_pkg::csa_cmd_t cmd;
  csa_pkg::csa_cmd_t pend_cmd;
  csa_pkg::csa_status_t st;
  logic cmd_neg;
  logic pend_neg;
  logic [15:0] dly_cnt;
  logic ovr_armed;
  logic signed [31:0] ramp_speed;
  logic signed [31:0] ramp_accel;
  logic reached;

  // Direction 4 follows the sign of the present speed
  wire in_neg = (in_cmd.dir == csa_pkg::DIR_NEG) ||
                (in_cmd.dir == csa_pkg::DIR_KEEP && ramp_speed < 0);
  // A waiting command is held only while the running one has not arrived
  wire running = (state != csa_pkg::ST_IDLE);
  wire defer = running && in_cmd.mode == csa_pkg::MODE_WAIT && !st.in_vel;
  wire start = exec_rise && cmd_ok && !defer;
  wire take_pend = st.pending && state == csa_pkg::ST_RUN && st.in_vel;
  wire arrive = state == csa_pkg::ST_RUN && reached && !st.in_vel && !take_pend;

  // Ramp goal; override replaces the magnitude
  wire [31:0] goal_mag = ovr_armed ? ovr_reg : cmd.vel;
  wire signed [31:0] goal = (state != csa_pkg::ST_RUN) ? 32'sh0000_0000 :
                            (cmd_neg ? -$signed(goal_mag) : $signed(goal_mag));

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      exec_prev <= 1'b0;
      ovr_reg <= csa_pkg::RST_WORD;
      ovr_valid <= 1'b0;
    end else begin
      exec_prev <= exec_lvl;
      if (wr_ovr) begin
        ovr_reg <= be_merge(ovr_reg, avs_writedata_in, avs_byteenable_in);
      end
      ovr_valid <= wr_ovr;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= csa_pkg::ST_IDLE;
      cmd <= '0;
      pend_cmd <= '0;
      cmd_neg <= 1'b0;
      pend_neg <= 1'b0;
      dly_cnt <= 16'h0000;
      ovr_armed <= 1'b0;
      st <= '0;
      error_code_out <= csa_pkg::ERR_NONE;
    end else begin
      // Set wins: a new abort in the clearing cycle keeps the flag
      st.aborted <= abort_evt && running || (st.aborted && exec_lvl);
      if (ovr_valid && running) begin
        ovr_armed <= 1'b1;
      end
      if (abort_evt && running) begin
        state <= csa_pkg::ST_IDLE;
        st.busy <= 1'b0;
        st.active <= 1'b0;
        st.in_vel <= 1'b0;
        st.pending <= 1'b0;
        ovr_armed <= 1'b0;
      end else if (exec_rise && !cmd_ok) begin
        st.error <= 1'b1;
        error_code_out <= chk_code;
      end else if (start) begin
        cmd <= in_cmd;
        cmd_neg <= in_neg;
        st.error <= 1'b0;
        st.in_vel <= 1'b0;
        st.pending <= 1'b0;
        ovr_armed <= 1'b0;
        error_code_out <= csa_pkg::ERR_NONE;
        if (state == csa_pkg::ST_RUN) begin
          state <= csa_pkg::ST_RUN;
        end else begin
          state <= csa_pkg::ST_DELAY;
          dly_cnt <= 16'(START_DELAY - 1);
        end
      end else if (exec_rise) begin
        pend_cmd <= in_cmd;
        pend_neg <= in_neg;
        st.pending <= 1'b1;
      end else if (take_pend) begin
        cmd <= pend_cmd;
        cmd_neg <= pend_neg;
        st.pending <= 1'b0;
        st.in_vel <= 1'b0;
        ovr_armed <= 1'b0;
      end else begin
        unique case (state)
          csa_pkg::ST_IDLE: begin
          end
          csa_pkg::ST_DELAY: begin
            if (dly_cnt == 16'h0000) begin
              state <= csa_pkg::ST_RUN;
              st.busy <= 1'b1;
              st.active <= 1'b1;
            end else begin
              dly_cnt <= dly_cnt - 16'h0001;
            end
          end
          csa_pkg::ST_RUN: begin
            // Execute level is not looked at here, so a falling edge changes nothing
            if (arrive) begin
              st.in_vel <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  csa_ramp #(
    .TICK_CYCLES(RAMP_TICK_CYCLES),
    .W(32)
  ) u_ramp (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .target_in(goal),
    .acc_in($signed(cmd.acc)),
    .dec_in($signed(cmd.dec)),
    .jerk_in($signed(cmd.jerk)),
    .speed_out(ramp_speed),
    .accel_out(ramp_accel),
    .reached_out(reached)
  );

  // Register read mux; unmapped addresses read zero
  wire [31:0] stat_word = {26'h000_0000, st};
  wire [31:0] rd_mux = (avs_address_in == csa_pkg::OFS_CTRL) ? ctrl :
                       (avs_address_in == csa_pkg::OFS_VEL) ? vel_reg :
                       (avs_address_in == csa_pkg::OFS_ACC) ? acc_reg :
                       (avs_address_in == csa_pkg::OFS_DEC) ? dec_reg :
                       (avs_address_in == csa_pkg::OFS_JERK) ? jerk_reg :
                       (avs_address_in == csa_pkg::OFS_OVERRIDE) ? ovr_reg :
                       (avs_address_in == csa_pkg::OFS_STATUS) ? stat_word :
                       (avs_address_in == csa_pkg::OFS_ERROR) ? {16'h0000, error_code_out} :
                       (avs_address_in == csa_pkg::OFS_SPEED) ? ramp_speed :
                       (avs_address_in == csa_pkg::OFS_ACCEL) ? ramp_accel : 32'h0000_0000;

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      avs_waitrequest_out <= ~(req & avs_waitrequest_out);
      if (avs_read_in && avs_waitrequest_out) begin
        avs_readdata_out <= rd_mux;
      end
    end
  end

  // Status pins mirror internal flops one cycle later
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      speed_out <= 32'sh0000_0000;
      axis_out <= 4'h0;
      busy_out <= 1'b0;
      active_out <= 1'b0;
      in_velocity_out <= 1'b0;
      aborted_flag_out <= 1'b0;
      error_out <= 1'b0;
    end else begin
      speed_out <= ramp_speed;
      axis_out <= cmd.axis;
      busy_out <= st.busy;
      active_out <= st.active;
      in_velocity_out <= st.in_vel;
      aborted_flag_out <= st.aborted;
      error_out <= st.error;
    end
  end
endmodule // csa_axis_cmd
`default_nettype wire

// ---- csa_axis_cmd_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module csa_axis_cmd_props #(
  parameter int RAMP_TICK_CYCLES = 2,
  parameter int START_DELAY = 2
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Bus handshake
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  // Motion status
  input wire logic signed [31:0] speed_out,
  input wire logic busy_out,
  input wire logic active_out,
  input wire logic in_velocity_out,
  input wire logic aborted_flag_out,
  input wire logic error_out,
  input wire logic [15:0] error_code_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  a_wait_one_cycle: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("waitrequest late");
  a_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
  a_wait_cause: assert property (!avs_waitrequest_out |-> $past(avs_read_in || avs_write_in))
    else $error("waitrequest low without request");
  a_busy_active_pair: assert property (busy_out == active_out)
    else $error("busy and active differ");
  a_speed_needs_busy: assert property (in_velocity_out |-> busy_out && active_out)
    else $error("at speed while idle");
  a_abort_clears: assert property ($rose(aborted_flag_out) |-> !busy_out && !active_out && !in_velocity_out)
    else $error("abort left flags set");
  a_error_coded: assert property ($rose(error_out) |-> error_code_out != 16'h0000)
    else $error("error without code");
  a_ramp_tick: assert property ($changed(speed_out) && RAMP_TICK_CYCLES > 1 |=> $stable(speed_out))
    else $error("speed changed off tick");
  a_reach_speed: assert property ($rose(in_velocity_out) |-> speed_out != 32'h0000_0000)
    else $error("at speed with zero speed");
endmodule // csa_axis_cmd_props
`default_nettype wire

// ---- csa_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module csa_host (
  // Clock
  input wire logic clk_in,
  // Avalon-MM master
  output logic [5:0] address_out,
  output logic read_out,
  output logic write_out,
  output logic [31:0] writedata_out,
  output logic [3:0] byteenable_out,
  input wire logic [31:0] readdata_in,
  input wire logic waitrequest_in
);
  initial begin
    address_out = 6'h00;
    read_out = 1'b0;
    write_out = 1'b0;
    writedata_out = 32'h0000_0000;
    byteenable_out = 4'hF;
  end
  // Entered just after an edge; the trailing edge keeps strobes from being driven twice in one step
  task automatic access(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    address_out <= a;
    writedata_out <= d;
    write_out <= wr;
    read_out <= !wr;
    // No local limit: a stuck slave is caught by the bench timeout
    do begin
      @(posedge clk_in);
    end while (waitrequest_in !== 1'b0);
    q = readdata_in;
    write_out <= 1'b0;
    read_out <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic command(input int vel, input int acc, input int jerk, input logic [31:0] ctrl);
    logic [31:0] q;
    access(1'b1, csa_pkg::OFS_VEL, 32'(vel), q);
    access(1'b1, csa_pkg::OFS_ACC, 32'(acc), q);
    access(1'b1, csa_pkg::OFS_DEC, 32'(acc), q);
    access(1'b1, csa_pkg::OFS_JERK, 32'(jerk), q);
    access(1'b1, csa_pkg::OFS_CTRL, ctrl, q);
    access(1'b1, csa_pkg::OFS_CTRL, ctrl | 32'h1, q);
  endtask
endmodule // csa_host
`default_nettype wire

// ---- csa_pkg.sv ----
`default_nettype none
package csa_pkg;
  // Bus geometry
  localparam int DATA_W = 32;
  localparam int ADDR_W = 6;
  // Register byte offsets
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_VEL = 6'h04;
  localparam logic [5:0] OFS_ACC = 6'h08;
  localparam logic [5:0] OFS_DEC = 6'h0C;
  localparam logic [5:0] OFS_JERK = 6'h10;
  localparam logic [5:0] OFS_OVERRIDE = 6'h14;
  localparam logic [5:0] OFS_STATUS = 6'h18;
  localparam logic [5:0] OFS_ERROR = 6'h1C;
  localparam logic [5:0] OFS_SPEED = 6'h20;
  localparam logic [5:0] OFS_ACCEL = 6'h24;
  // Control word fields
  localparam int CTRL_EXEC = 0;
  localparam int CTRL_DIR_LSB = 1;
  localparam int CTRL_MODE = 4;
  localparam int CTRL_FIELDBUS = 5;
  localparam int CTRL_AXIS_EN = 6;
  localparam int CTRL_ABORT = 7;
  localparam int CTRL_AXIS_LSB = 8;
  // Status word fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_ACTIVE = 1;
  localparam int STAT_IN_VEL = 2;
  localparam int STAT_ABORTED = 3;
  localparam int STAT_ERROR = 4;
  localparam int STAT_PENDING = 5;
  // Direction and transfer mode codes
  localparam logic [2:0] DIR_POS = 3'h1;
  localparam logic [2:0] DIR_NEG = 3'h3;
  localparam logic [2:0] DIR_KEEP = 3'h4;
  localparam logic MODE_INTERRUPT = 1'b0;
  localparam logic MODE_WAIT = 1'b1;
  // Axis number limits
  localparam logic [3:0] AXIS_MAX_LOCAL = 4'hB;
  localparam logic [3:0] AXIS_MAX_FIELDBUS = 4'hF;
  // Error codes
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_NOT_ENABLED = 16'h0001;
  localparam logic [15:0] ERR_AXIS = 16'h0002;
  localparam logic [15:0] ERR_DIR = 16'h0003;
  localparam logic [15:0] ERR_PARAM = 16'h0004;
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [2:0] RST_DIR = 3'h1;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int START_DELAY_NS = 1000;
  localparam int START_DELAY_CYCLES = (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAMP_TICK_NS = 1000000;
  localparam int RAMP_TICK_CYCLES = RAMP_TICK_NS / CLK_PERIOD_NS;
  typedef struct packed {
    logic [31:0] vel;
    logic [31:0] acc;
    logic [31:0] dec;
    logic [31:0] jerk;
    logic [2:0] dir;
    logic mode;
    logic [3:0] axis;
  } csa_cmd_t;
  typedef struct packed {
    logic pending;
    logic error;
    logic aborted;
    logic in_vel;
    logic active;
    logic busy;
  } csa_status_t;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_RUN} csa_state_t;
endpackage
`default_nettype wire

// ---- csa_ramp.sv ----
`timescale 1ns/1ps
`default_nettype none
module csa_ramp #(
  parameter int TICK_CYCLES = 10000,
  parameter int W = 32
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Profile limits
  input wire logic signed [W-1:0] target_in,
  input wire logic signed [W-1:0] acc_in,
  input wire logic signed [W-1:0] dec_in,
  input wire logic signed [W-1:0] jerk_in,
  // Profile state
  output logic signed [W-1:0] speed_out,
  output logic signed [W-1:0] accel_out,
  output logic reached_out
);
  if (TICK_CYCLES < 1 || W < 8) begin : g_bad
    $error("csa_ramp: unsupported parameters");
  end
  logic [31:0] tick_cnt;
  wire tick = (tick_cnt == 32'h0000_0000);
  wire signed [W+1:0] spd = {{2{speed_out[W-1]}}, speed_out};
  wire signed [W+1:0] acl = {{2{accel_out[W-1]}}, accel_out};
  wire signed [W+1:0] tgt = {{2{target_in[W-1]}}, target_in};
  wire signed [W+1:0] err = tgt - spd;
  // Magnitude growing uses the acceleration limit, shrinking the deceleration
  wire growing = (err > 0 && spd >= 0) || (err < 0 && spd <= 0);
  wire signed [W+1:0] lim = growing ? {{2{acc_in[W-1]}}, acc_in} : {{2{dec_in[W-1]}}, dec_in};
  wire signed [W+1:0] jrk = {{2{jerk_in[W-1]}}, jerk_in};
  wire signed [W+1:0] want = (err > 0) ? lim : ((err < 0) ? -lim : '0);
  wire signed [W+1:0] up = (acl + jrk > want) ? want : acl + jrk;
  wire signed [W+1:0] down = (acl - jrk < want) ? want : acl - jrk;
  wire signed [W+1:0] stepped = (acl < want) ? up : down;
  wire signed [W+1:0] cand = spd + stepped;
  // Clamp at the target so the profile never overshoots
  wire over = (err > 0 && cand >= tgt) || (err < 0 && cand <= tgt) || (err == 0);
  wire signed [W-1:0] next_speed = over ? target_in : cand[W-1:0];
  wire signed [W-1:0] next_accel = over ? '0 : stepped[W-1:0];
  assign reached_out = (speed_out == target_in);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt <= 32'h0000_0000;
      speed_out <= '0;
      accel_out <= '0;
    end else begin
      tick_cnt <= tick ? 32'(TICK_CYCLES - 1) : tick_cnt - 32'h0000_0001;
      if (tick) begin
        speed_out <= next_speed;
        accel_out <= next_accel;
      end
    end
  end
endmodule // csa_ramp
`default_nettype wire

// ---- placeholder_none.sv ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [5:0] addr;
  logic rd_en;
  logic wr_en;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0] be;
  logic wreq;
  logic signed [31:0] speed;
  logic [3:0] axis;
  logic busy;
  logic active;
  logic in_vel;
  logic aborted;
  logic err;
  logic [15:0] err_code;
  logic [31:0] q;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  initial begin
    forever #50 clk = ~clk;
  end
  csa_host csa_host_inst (.clk_in(clk), .address_out(addr), .read_out(rd_en), .write_out(wr_en),
    .writedata_out(wdata), .byteenable_out(be), .readdata_in(rdata), .waitrequest_in(wreq));
  csa_axis_cmd #(.RAMP_TICK_CYCLES(2), .START_DELAY(2)) csa_axis_cmd_inst (.sys_clk_in(clk), .nrst_in(nrst),
    .avs_address_in(addr), .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .speed_out(speed),
    .axis_out(axis), .busy_out(busy), .active_out(active), .in_velocity_out(in_vel),
    .aborted_flag_out(aborted), .error_out(err), .error_code_out(err_code));
  task automatic tally_and_finish();
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Axis stays enabled unless a case wants the refusal
  function automatic logic [31:0] ctl(input logic [2:0] dir, input logic mode, input logic [3:0] ax,
      input logic fb = 1'b0, input logic en = 1'b1);
    return {20'h0_0000, ax, 1'b0, en, fb, mode, dir, 1'b0};
  endfunction
  function automatic logic flag(input int k);
    case (k)
      0: return busy;
      1: return in_vel;
      2: return aborted;
      default: return err;
    endcase
  endfunction
  // Bounded so a stuck flag ends in a mismatch, not a hang
  task automatic wait_flag(input int k, input logic lvl);
    for (int n = 0; n < 600 && flag(k) !== lvl; n++) @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    csa_host_inst.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a);
    csa_host_inst.access(1'b0, a, 32'h0000_0000, q);
  endtask
  task automatic s_reset();
    rd(csa_pkg::OFS_CTRL);
    check("ctrl", q, 32'h0000_0002);
    rd(csa_pkg::OFS_STATUS);
    check("status", q, 32'h0000_0000);
    wr(6'h3C, 32'hFFFF_FFFF);
    rd(6'h3C);
    check("unmapped", q, 32'h0000_0000);
  endtask
  task automatic s_held();
    csa_host_inst.command(6, 2, 1, ctl(3'h1, 1'b0, 4'h0));
    wait_flag(0, 1'b1);
    check("active", 32'(active), 32'h1);
    wait_flag(1, 1'b1);
    check("speed", speed, 32'h0000_0006);
    wr(csa_pkg::OFS_VEL, 32'h0000_0009);
    wr(csa_pkg::OFS_CTRL, ctl(3'h1, 1'b0, 4'h0) | 32'h1);
    repeat (40) @(posedge clk);
    check("held", speed, 32'h0000_0006);
    wr(csa_pkg::OFS_CTRL, ctl(3'h1, 1'b0, 4'h0));
    repeat (20) @(posedge clk);
    check("fall", 32'({busy, in_vel}), 32'h3);
  endtask
  task automatic s_restart();
    csa_host_inst.command(9, 2, 1, ctl(3'h3, 1'b0, 4'h0));
    wr(csa_pkg::OFS_CTRL, ctl(3'h3, 1'b0, 4'h0));
    rd(csa_pkg::OFS_STATUS);
    check("no pending", q & 32'h0000_0020, 32'h0000_0000);
    check("kept busy", 32'(busy), 32'h1);
    wait_flag(1, 1'b1);
    check("reverse", speed, 32'hFFFF_FFF7);
    check("busy", 32'(busy & active), 32'h1);
    csa_host_inst.command(4, 2, 1, ctl(3'h4, 1'b0, 4'h0));
    wait_flag(1, 1'b0);
    wait_flag(1, 1'b1);
    check("keep dir", speed, 32'hFFFF_FFFC);
  endtask
  task automatic s_override();
    wr(csa_pkg::OFS_OVERRIDE, 32'h0000_0007);
    repeat (40) @(posedge clk);
    check("kept at speed", 32'(in_vel), 32'h1);
    csa_host_inst.command(10, 2, 1, ctl(3'h1, 1'b0, 4'h0));
    wr(csa_pkg::OFS_OVERRIDE, 32'h0000_0005);
    wait_flag(1, 1'b0);
    wait_flag(1, 1'b1);
    check("override", speed, 32'h0000_0005);
  endtask
  task automatic s_queue_and_abort();
    csa_host_inst.command(100, 2, 1, ctl(3'h1, 1'b0, 4'h0));
    csa_host_inst.command(3, 2, 1, ctl(3'h1, 1'b1, 4'h0));
    rd(csa_pkg::OFS_STATUS);
    check("pending", q & 32'h0000_0020, 32'h0000_0020);
    // The running command reports arrival for one cycle before the queued one takes over
    wait_flag(1, 1'b1);
    check("first done", speed, 32'h0000_0064);
    wait_flag(1, 1'b0);
    wait_flag(1, 1'b1);
    check("queued", speed, 32'h0000_0003);
    wr(csa_pkg::OFS_CTRL, ctl(3'h1, 1'b1, 4'h0) | 32'h0000_0081);
    wait_flag(2, 1'b1);
    check("aborted", 32'({busy, active, in_vel}), 32'h0);
    repeat (10) @(posedge clk);
    check("abort held", 32'(aborted), 32'h1);
    wr(csa_pkg::OFS_CTRL, ctl(3'h1, 1'b1, 4'h0));
    wait_flag(2, 1'b0);
    check("abort clear", 32'(aborted), 32'h0);
  endtask
  task automatic s_errors();
    logic [31:0] c [7] = '{ctl(3'h1, 1'b0, 4'h0, 1'b0, 1'b0), ctl(3'h1, 1'b0, 4'hC), ctl(3'h2, 1'b0, 4'h0),
      ctl(3'h1, 1'b0, 4'h0), ctl(3'h1, 1'b0, 4'h0), ctl(3'h1, 1'b0, 4'hF, 1'b1), ctl(3'h3, 1'b0, 4'hB)};
    int v [7] = '{5, 5, 5, 0, 5, 5, 5};
    int j [7] = '{1, 1, 1, 1, -1, 1, 1};
    logic [15:0] e [7] = '{csa_pkg::ERR_NOT_ENABLED, csa_pkg::ERR_AXIS, csa_pkg::ERR_DIR, csa_pkg::ERR_PARAM,
      csa_pkg::ERR_PARAM, csa_pkg::ERR_NONE, csa_pkg::ERR_NONE};
    for (int k = 0; k < 7; k++) begin
      csa_host_inst.command(v[k], 2, j[k], c[k]);
      rd(csa_pkg::OFS_ERROR);
      check("code", q, {16'h0000, e[k]});
      check("code pin", 32'(err_code), 32'(e[k]));
      wait_flag(3, e[k] != 16'h0000);
      check("error pin", 32'(err), 32'(e[k] != 16'h0000));
    end
    wait_flag(0, 1'b1);
    check("axis", 32'(axis), 32'h0000_000B);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    s_reset();
    s_held();
    s_restart();
    s_override();
    s_queue_and_abort();
    s_errors();
    tally_and_finish();
  end
endmodule // testbench
bind csa_axis_cmd csa_axis_cmd_props #(.RAMP_TICK_CYCLES(RAMP_TICK_CYCLES), .START_DELAY(START_DELAY))
  csa_axis_cmd_props_inst (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out), .speed_out(speed_out),
  .busy_out(busy_out), .active_out(active_out), .in_velocity_out(in_velocity_out),
  .aborted_flag_out(aborted_flag_out), .error_out(error_out), .error_code_out(error_code_out));
`default_nettype wire
